//--- rtl/vtpc_pkg.sv
package vtpc_pkg;
	// ----------------------------------------
	// Register map and field layout
	// ----------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h64;
	localparam logic [7:0] CTRL_RST = 8'h10;
	localparam logic [7:0] CTRL_WMASK = 8'hF7; // Bit 3 reserved
	localparam int SEL_HI = 7;
	localparam int SEL_LO = 4;
	localparam int BARS_BIT = 2;
	localparam int REV_BIT = 1;
	localparam int EN_BIT = 0;
	// ----------------------------------------
	// Pattern selection codes
	// ----------------------------------------
	localparam logic [3:0] PAT_CHECKER = 4'h0;
	localparam logic [3:0] PAT_WHITE = 4'h1;
	localparam logic [3:0] PAT_BLACK = 4'h2;
	localparam logic [3:0] PAT_RED = 4'h3;
	localparam logic [3:0] PAT_GREEN = 4'h4;
	localparam logic [3:0] PAT_BLUE = 4'h5;
	localparam logic [3:0] PAT_HR_WHITE = 4'h6;
	localparam logic [3:0] PAT_HR_RED = 4'h7;
	localparam logic [3:0] PAT_HR_GREEN = 4'h8;
	localparam logic [3:0] PAT_VR_BLUE = 4'h9;
	localparam logic [3:0] PAT_VR_RED = 4'hA;
	localparam logic [3:0] PAT_VR_GREEN = 4'hC;
	localparam logic [3:0] PAT_VR_BLUE2 = 4'hD;
	localparam logic [3:0] PAT_CUSTOM = 4'hE;
	localparam logic [3:0] PAT_BAND = 4'hF;
	// ----------------------------------------
	// Colors, ramp and buffer constants
	// ----------------------------------------
	localparam logic [23:0] C_WHITE = 24'hFFFFFF;
	localparam logic [23:0] C_BLACK = 24'h000000;
	localparam logic [23:0] C_RED = 24'hFF0000;
	localparam logic [23:0] C_GREEN = 24'h00FF00;
	localparam logic [23:0] C_BLUE = 24'h0000FF;
	localparam logic [23:0] C_YELLOW = 24'hFFFF00;
	localparam logic [23:0] C_CYAN = 24'h00FFFF;
	localparam logic [23:0] C_MAGENTA = 24'hFF00FF;
	localparam logic [12:0] RAMP_STEPS = 13'h0100; // Levels per ramp
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	// ----------------------------------------
	// Pixel carrier
	// ----------------------------------------
	typedef struct packed {
		logic de;
		logic hs;
		logic vs;
		logic [23:0] rgb;
	} vtpc_pix_t;
endpackage

//--- rtl/vtpc_top.sv
`timescale 1ns/100ps
module vtpc_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_we,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic auto_scroll_en,
	input wire logic color_invert,
	input wire logic [7:0] custom_red_level,
	input wire logic [7:0] custom_green_level,
	input wire logic [7:0] custom_blue_level,
	input wire logic [11:0] h_active,
	input wire logic [11:0] v_active,
	input wire logic in_valid,
	output logic in_ready,
	input vtpc_pkg::vtpc_pix_t in_pix,
	output logic out_valid,
	input wire logic out_ready,
	output vtpc_pkg::vtpc_pix_t out_pix
);
	// ----------------------------------------
	// Register port
	// ----------------------------------------
	logic [7:0] ctrl_ff;
	logic ctrl_hit;
	assign ctrl_hit = reg_addr == vtpc_pkg::CTRL_ADDR;

	// Control register with reserved bit held low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_ff <= vtpc_pkg::CTRL_RST;
		end else if (reg_we && ctrl_hit) begin
			ctrl_ff <= reg_wdata & vtpc_pkg::CTRL_WMASK;
		end
	end

	// Registered read data, unmapped addresses read zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= ctrl_hit ? ctrl_ff : 8'h00;
		end
	end

	logic [3:0] sel;
	logic gen_en, bars_on, band_rev;
	assign sel = ctrl_ff[vtpc_pkg::SEL_HI:vtpc_pkg::SEL_LO];
	assign gen_en = ctrl_ff[vtpc_pkg::EN_BIT];
	assign bars_on = ctrl_ff[vtpc_pkg::BARS_BIT];
	assign band_rev = ctrl_ff[vtpc_pkg::REV_BIT];

	// ----------------------------------------
	// Position and ramp tracking
	// ----------------------------------------
	logic push;
	logic [11:0] x_ff, hacc_ff, vacc_ff;
	logic [7:0] hlev_ff, vlev_ff;
	logic de_prev_ff;
	logic [19:0] nxt_h, nxt_v;

	// One ramp step: even spreading of RAMP_STEPS levels over size pixels
	function automatic logic [19:0] ramp_step(input logic [11:0] acc, input logic [7:0] lev,
		input logic [11:0] size);
		logic [12:0] sum;
		sum = {1'b0, acc} + vtpc_pkg::RAMP_STEPS;
		if (sum >= {1'b0, size}) begin
			ramp_step = {12'(sum - {1'b0, size}), 8'(lev + 8'h01)};
		end else begin
			ramp_step = {sum[11:0], lev};
		end
	endfunction

	assign nxt_h = ramp_step(hacc_ff, hlev_ff, h_active);
	assign nxt_v = ramp_step(vacc_ff, vlev_ff, v_active);

	// Horizontal position restarts on every blanking beat
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			x_ff <= 12'h000;
			hacc_ff <= 12'h000;
			hlev_ff <= 8'h00;
		end else if (push) begin
			if (in_pix.de) begin
				x_ff <= x_ff + 12'h001;
				{hacc_ff, hlev_ff} <= nxt_h;
			end else begin
				x_ff <= 12'h000;
				hacc_ff <= 12'h000;
				hlev_ff <= 8'h00;
			end
		end
	end

	// Vertical level steps at each line end, restarts on vertical sync
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			vacc_ff <= 12'h000;
			vlev_ff <= 8'h00;
			de_prev_ff <= 1'b0;
		end else if (push) begin
			de_prev_ff <= in_pix.de;
			if (in_pix.vs) begin
				vacc_ff <= 12'h000;
				vlev_ff <= 8'h00;
			end else if (de_prev_ff && !in_pix.de) begin
				{vacc_ff, vlev_ff} <= nxt_v;
			end
		end
	end

	// ----------------------------------------
	// Pattern generation
	// ----------------------------------------
	function automatic logic [23:0] bar_color(input logic [2:0] idx);
		case (idx)
			3'h0: bar_color = vtpc_pkg::C_WHITE;
			3'h1: bar_color = vtpc_pkg::C_YELLOW;
			3'h2: bar_color = vtpc_pkg::C_CYAN;
			3'h3: bar_color = vtpc_pkg::C_GREEN;
			3'h4: bar_color = vtpc_pkg::C_MAGENTA;
			3'h5: bar_color = vtpc_pkg::C_RED;
			3'h6: bar_color = vtpc_pkg::C_BLUE;
			default: bar_color = vtpc_pkg::C_BLACK;
		endcase
	endfunction

	function automatic logic [23:0] band_color(input logic [1:0] idx, input logic rev);
		logic [1:0] k;
		k = rev ? ~idx : idx;
		case (k)
			2'h0: band_color = vtpc_pkg::C_YELLOW;
			2'h1: band_color = vtpc_pkg::C_CYAN;
			2'h2: band_color = vtpc_pkg::C_BLUE;
			default: band_color = vtpc_pkg::C_RED;
		endcase
	endfunction

	logic check_on;
	logic [23:0] base_rgb, inv_mask;
	vtpc_pkg::vtpc_pix_t gen_pix;
	assign check_on = x_ff[0] ^ vlev_ff[0];
	assign inv_mask = color_invert ? vtpc_pkg::C_WHITE : vtpc_pkg::C_BLACK;

	// Base color of the selected pattern in its normal form
	always_comb begin
		base_rgb = vtpc_pkg::C_WHITE;
		if (bars_on) begin
			base_rgb = bar_color(hlev_ff[7:5]);
		end else if (auto_scroll_en) begin
			base_rgb = vtpc_pkg::C_WHITE;
		end else begin
			case (sel)
				vtpc_pkg::PAT_CHECKER: base_rgb = check_on ? vtpc_pkg::C_WHITE : vtpc_pkg::C_BLACK;
				vtpc_pkg::PAT_WHITE: base_rgb = vtpc_pkg::C_WHITE;
				vtpc_pkg::PAT_BLACK: base_rgb = vtpc_pkg::C_BLACK;
				vtpc_pkg::PAT_RED: base_rgb = vtpc_pkg::C_RED;
				vtpc_pkg::PAT_GREEN: base_rgb = vtpc_pkg::C_GREEN;
				vtpc_pkg::PAT_BLUE: base_rgb = vtpc_pkg::C_BLUE;
				vtpc_pkg::PAT_HR_WHITE: base_rgb = {3{hlev_ff}};
				vtpc_pkg::PAT_HR_RED: base_rgb = {hlev_ff, 16'h0000};
				vtpc_pkg::PAT_HR_GREEN: base_rgb = {8'h00, hlev_ff, 8'h00};
				vtpc_pkg::PAT_VR_BLUE, vtpc_pkg::PAT_VR_BLUE2: base_rgb = {16'h0000, vlev_ff};
				vtpc_pkg::PAT_VR_RED: base_rgb = {vlev_ff, 16'h0000};
				vtpc_pkg::PAT_VR_GREEN: base_rgb = {8'h00, vlev_ff, 8'h00};
				vtpc_pkg::PAT_CUSTOM: base_rgb = {custom_red_level, custom_green_level,
					custom_blue_level};
				vtpc_pkg::PAT_BAND: base_rgb = check_on ? band_color(vlev_ff[7:6], band_rev) :
					vtpc_pkg::C_BLACK;
				default: base_rgb = vtpc_pkg::C_WHITE;
			endcase
		end
	end

	// Replace active pixels and force blanking pixels black while enabled, otherwise pass through
	always_comb begin
		gen_pix = in_pix;
		if (gen_en) begin
			gen_pix.rgb = in_pix.de ? (base_rgb ^ inv_mask) : vtpc_pkg::C_BLACK;
		end
	end

	// ----------------------------------------
	// Two-entry output buffer
	// ----------------------------------------
	vtpc_pkg::vtpc_pix_t ent0_ff, ent1_ff;
	logic [1:0] cnt_ff;
	logic pop;
	assign in_ready = cnt_ff != vtpc_pkg::BUF_DEPTH;
	assign push = in_valid && in_ready;
	assign out_valid = cnt_ff != 2'h0;
	assign pop = out_valid && out_ready;
	assign out_pix = ent0_ff;

	// Fill level
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_ff <= 2'h0;
		end else if (push && !pop) begin
			cnt_ff <= cnt_ff + 2'h1;
		end else if (pop && !push) begin
			cnt_ff <= cnt_ff - 2'h1;
		end
	end

	// Entry storage, head in entry 0
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ent0_ff <= '0;
			ent1_ff <= '0;
		end else begin
			if (pop) begin
				ent0_ff <= (cnt_ff == 2'h2) ? ent1_ff : gen_pix;
				if (push && cnt_ff == 2'h2) begin
					ent1_ff <= gen_pix;
				end
			end else if (push) begin
				if (cnt_ff == 2'h0) begin
					ent0_ff <= gen_pix;
				end else begin
					ent1_ff <= gen_pix;
				end
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_ctrl_write;
		reg_we && ctrl_hit;
	endsequence
	sequence s_fixed_active;
		gen_en && in_pix.de && !bars_on && !auto_scroll_en;
	endsequence

	ctrl_reset_a: assert property (@(posedge sys_clk) rst |=> ctrl_ff == 8'h10)
		else $error("control register reset value wrong");
	rsvd_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
		s_ctrl_write ##1 ctrl_hit |=> reg_rdata[3] == 1'b0)
		else $error("reserved bit reads nonzero");
	ctrl_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		s_ctrl_write |=> ctrl_ff == ($past(reg_wdata) & 8'hF7))
		else $error("control write not stored");
	pass_thru_a: assert property (@(posedge sys_clk) disable iff (rst)
		!gen_en |-> gen_pix == in_pix)
		else $error("disabled generator altered pixels");
	white_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
		s_fixed_active and sel == 4'h1 |-> gen_pix.rgb == ~inv_mask)
		else $error("white field wrong");
	bars_over_a: assert property (@(posedge sys_clk) disable iff (rst)
		gen_en && in_pix.de && bars_on |-> gen_pix.rgb == (bar_color(hlev_ff[7:5]) ^ inv_mask))
		else $error("color bars not forced");
	auto_ign_a: assert property (@(posedge sys_clk) disable iff (rst)
		gen_en && in_pix.de && !bars_on && auto_scroll_en |-> gen_pix.rgb == ~inv_mask)
		else $error("selection used in auto-scroll");
	invert_a: assert property (@(posedge sys_clk) disable iff (rst)
		gen_en && in_pix.de && color_invert |-> gen_pix.rgb == ~base_rgb)
		else $error("inverted form wrong");
	custom_a: assert property (@(posedge sys_clk) disable iff (rst)
		s_fixed_active and sel == 4'hE && !color_invert |->
		gen_pix.rgb == {custom_red_level, custom_green_level, custom_blue_level})
		else $error("custom color wrong");
	band_order_a: assert property (@(posedge sys_clk) disable iff (rst)
		s_fixed_active and sel == 4'hF && check_on && !color_invert && vlev_ff[7:6] == 2'h0 |->
		gen_pix.rgb == (band_rev ? 24'hFF0000 : 24'hFFFF00))
		else $error("band order wrong");
	ramp_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		push && !in_pix.de |=> hlev_ff == 8'h00)
		else $error("ramp does not restart at line start");
	buf_full_a: assert property (@(posedge sys_clk) disable iff (rst)
		cnt_ff == 2'h2 |-> !in_ready ##0 out_valid)
		else $error("full buffer accepts data");
endmodule // vtpc_top

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic sys_clk, rst, reg_we, auto_scroll_en, color_invert, in_valid, in_ready;
	logic out_valid, out_ready;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [11:0] h_active, v_active;
	logic [7:0] custom_red_level, custom_green_level, custom_blue_level;
	vtpc_pkg::vtpc_pix_t in_pix, out_pix, q[$];
	int n_errors = 0;
	int checked = 0;
	vtpc_top vtpc_top_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_we(reg_we),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .auto_scroll_en(auto_scroll_en),
		.color_invert(color_invert), .custom_red_level(custom_red_level),
		.custom_green_level(custom_green_level),
		.custom_blue_level(custom_blue_level), .h_active(h_active), .v_active(v_active),
		.in_valid(in_valid), .in_ready(in_ready), .in_pix(in_pix), .out_valid(out_valid),
		.out_ready(out_ready), .out_pix(out_pix));
	// ----------------------------------------
	// Clock and output capture
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Collect every pixel taken by the sink
	always @(posedge sys_clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) q.push_back(out_pix);
	end
	// ----------------------------------------
	// Compare and drive tasks
	// ----------------------------------------
	task automatic fail(input string m);
		n_errors++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) fail($sformatf("register read %h, want %h", g, e));
	endtask
	task automatic chk_bit(input logic g, input logic e);
		checked++;
		if (g !== e) fail("handshake flag wrong");
	endtask
	task automatic chk_pix(input vtpc_pkg::vtpc_pix_t g, input vtpc_pkg::vtpc_pix_t e);
		checked++;
		if (g !== e) fail($sformatf("pixel %h, want %h", g, e));
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = vtpc_pkg::CTRL_ADDR;
		reg_we = 1'b1;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_we = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		reg_addr = a;
		repeat (2) @(negedge sys_clk);
		chk_reg(reg_rdata, e);
	endtask
	task automatic send(input logic [26:0] p);
		int i;
		@(negedge sys_clk);
		in_valid = 1'b1;
		in_pix = p;
		for (i = 0; i < 50 && in_ready !== 1'b1; i++) @(negedge sys_clk);
		@(negedge sys_clk);
		in_valid = 1'b0;
	endtask
	task automatic get(output vtpc_pkg::vtpc_pix_t g);
		int i;
		g = '0;
		for (i = 0; i < 20 && q.size() == 0; i++) @(negedge sys_clk);
		if (q.size() == 0) fail("no pixel came out");
		else g = q.pop_front();
	endtask
	task automatic expect_pix(input logic [26:0] e);
		vtpc_pkg::vtpc_pix_t g;
		get(g);
		chk_pix(g, e);
	endtask
	// Line start beat, then one active pixel compared with the pattern
	task automatic pat(input logic [23:0] e);
		send({3'b010, 24'hFFFFFF});
		expect_pix({3'b010, 24'h000000});
		send({3'b100, 24'h123456});
		expect_pix({3'b100, e});
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd(vtpc_pkg::CTRL_ADDR, vtpc_pkg::CTRL_RST);
		rd(8'h65, 8'h00);
		wr(8'hFF);
		rd(vtpc_pkg::CTRL_ADDR, 8'hF7);
		wr(8'h20);
		send({3'b111, 24'hA5C3E1});
		expect_pix({3'b111, 24'hA5C3E1});
	endtask
	task automatic t_fields;
		logic [3:0] code [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hB, 4'hE};
		logic [23:0] col [7] = '{24'hFFFFFF, 24'h000000, 24'hFF0000, 24'h00FF00, 24'h0000FF,
			24'hFFFFFF, 24'h123456};
		for (int v = 0; v < 2; v++) begin
			color_invert = v[0];
			for (int k = 0; k < 7; k++) begin
				wr({code[k], 4'h1});
				pat(col[k] ^ {24{v[0]}});
			end
		end
		color_invert = 1'b0;
	endtask
	task automatic t_override;
		wr(8'h21);
		auto_scroll_en = 1'b1;
		pat(24'hFFFFFF);
		auto_scroll_en = 1'b0;
		wr(8'h25);
		pat(24'hFFFFFF);
	endtask
	task automatic t_ramp;
		logic [23:0] stp [3] = '{24'h010101, 24'h010000, 24'h000100};
		for (int k = 0; k < 3; k++) begin
			wr({4'h6 + 4'(k), 4'h1});
			pat(24'h000000);
			send({3'b100, 24'h0});
			expect_pix({3'b100, stp[k]});
		end
	endtask
	// Vertical ramps step once per line end
	task automatic t_vramp;
		logic [3:0] code [4] = '{4'h9, 4'hA, 4'hC, 4'hD};
		logic [23:0] stp [4] = '{24'h000001, 24'h010000, 24'h000100, 24'h000001};
		for (int k = 0; k < 4; k++) begin
			wr({code[k], 4'h1});
			send({3'b001, 24'h0});
			expect_pix({3'b001, 24'h0});
			send({3'b100, 24'h0});
			expect_pix({3'b100, 24'h0});
			send({3'b000, 24'h0});
			expect_pix({3'b000, 24'h0});
			send({3'b100, 24'h0});
			expect_pix({3'b100, stp[k]});
		end
	endtask
	task automatic t_checkered;
		logic [7:0] ctl [3] = '{8'h01, 8'hF1, 8'hF3};
		logic [23:0] col [3] = '{24'hFFFFFF, 24'hFFFF00, 24'hFF0000};
		vtpc_pkg::vtpc_pix_t a, b;
		for (int k = 0; k < 3; k++) begin
			wr(ctl[k]);
			send({3'b001, 24'h0});
			expect_pix({3'b001, 24'h0});
			send({3'b100, 24'h0});
			send({3'b100, 24'h0});
			get(a);
			get(b);
			chk_pix(a | b, {3'b100, col[k]});
		end
	endtask
	task automatic t_buffer;
		wr(8'h10);
		out_ready = 1'b0;
		send({3'b100, 24'h111111});
		send({3'b100, 24'h222222});
		chk_bit(in_ready, 1'b0);
		chk_bit(out_valid, 1'b1);
		out_ready = 1'b1;
		expect_pix({3'b100, 24'h111111});
		expect_pix({3'b100, 24'h222222});
	endtask
	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic print_verdict;
		if (n_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#(50 * 20000);
		fail("watchdog expired");
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_we = 1'b0;
		reg_wdata = 8'h00;
		auto_scroll_en = 1'b0;
		color_invert = 1'b0;
		h_active = 12'h100;
		v_active = 12'h100;
		custom_red_level = 8'h12;
		custom_green_level = 8'h34;
		custom_blue_level = 8'h56;
		in_valid = 1'b0;
		in_pix = '0;
		out_ready = 1'b1;
		repeat (10) @(negedge sys_clk);
		rst = 1'b0;
		t_regs();
		t_fields();
		t_override();
		t_ramp();
		t_vramp();
		t_checkered();
		t_buffer();
		print_verdict();
	end
endmodule // testbench
